// File: src/dual_slave_pkg.sv
// constants, register map and types of the dual slave bit interface
package dual_slave_pkg;
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TX_BIT_TIME_NS = 10000;
	localparam int unsigned TX_BIT_CYCLES = (TX_BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] TX_DIV_LAST = 12'(TX_BIT_CYCLES - 1);
	localparam logic [4:0] TX_LAST_BIT = 5'h1f;

	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0c;
	localparam logic [7:0] RX_DATA_OFFSET = 8'h10;
	localparam logic [7:0] TX_DATA_OFFSET = 8'h14;
	localparam logic [7:0] DIAG_CODE_OFFSET = 8'h18;

	localparam int CTRL_BUS_SETPOINT = 0;
	localparam int CTRL_CYCLIC = 1;
	localparam int CTRL_TX_START = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	localparam int IRQ_RX_DONE = 0;
	localparam int IRQ_TX_DONE = 1;
	localparam int IRQ_FAULT_ACK = 2;
	localparam int IRQ_DIAG_REQ = 3;
	localparam logic [3:0] IRQ_RESET = 4'h0;

	localparam logic [7:0] DIAG_RESET = 8'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	localparam int SYNC_W = 13;
	localparam logic [12:0] SYNC_RESET = 13'h0000;
	localparam int SYN_S1_CLK = 0;
	localparam int SYN_S1_DATA = 1;
	localparam int SYN_S1_QSTOP = 2;
	localparam int SYN_S1_SEL = 3;
	localparam int SYN_S2_LO = 4;
	localparam int SYN_S2_SEL = 7;
	localparam int SYN_LOCAL_LO = 8;
	localparam int SYN_DIAG = 12;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_DATA = 2'b01,
		TX_CLOCK = 2'b11
	} tx_state_type;
endpackage : dual_slave_pkg

// File: src/serial_tx.sv
// bit-serial transmitter of the parameter channel toward the master
`timescale 1ns/100ps
module serial_tx
	import dual_slave_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bit_en,
	input wire logic start,
	input wire logic cyclic,
	input wire logic [31:0] word,
	output logic tx_data,
	output logic tx_clk,
	output logic busy,
	output logic done
);
	tx_state_type state_r;
	tx_state_type state_nxt;
	logic [31:0] shift_r;
	logic [4:0] cnt_r;
	wire last_bit = (cnt_r == TX_LAST_BIT);
	wire restart = last_bit & cyclic;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			TX_IDLE: if (start) state_nxt = TX_DATA;
			TX_DATA: if (bit_en) state_nxt = TX_CLOCK;
			TX_CLOCK: if (bit_en) state_nxt = (last_bit & ~cyclic) ? TX_IDLE : TX_DATA;
			default: state_nxt = TX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= TX_IDLE;
			shift_r <= WORD_RESET;
			cnt_r <= 5'h00;
			tx_data <= 1'b0;
			tx_clk <= 1'b0;
			done <= 1'b0;
		end else begin
			state_r <= state_nxt;
			done <= 1'b0;
			if (state_r == TX_IDLE && start) begin
				shift_r <= word;
				cnt_r <= 5'h00;
			end
			// data settles a full bit time before the clock toggles [R8] [R13]
			if (state_r == TX_DATA && bit_en) begin
				tx_data <= shift_r[31];
				shift_r <= {shift_r[30:0], 1'b0};
			end
			if (state_r == TX_CLOCK && bit_en) begin
				tx_clk <= ~tx_clk;
				cnt_r <= cnt_r + 5'h01;
				// cyclic mode reloads the latest word, acyclic stops [R9]
				if (last_bit) begin
					done <= 1'b1;
					if (restart) shift_r <= word;
				end
			end
		end
	end

	assign busy = (state_r != TX_IDLE);
endmodule : serial_tx

// File: src/dual_slave_bit_interface.sv
// two-slave process bit interpreter with apb registers
// Behaviour
// [R1] two logical slaves, each with four output and four input bits
// [R2] output bit 3 of each slave is the slave A/B select, kept internally
// [R3] fixed mode: slave 2 bits 0..2 form binary speed code, bit 0 lsb
// [R4] code zero commands ramp-down stop; code n runs at fixed speed n
// [R5] slave 2 inputs: ready, pulses enabled, local input 0, local input 1
// [R6] diagnostic request makes slave 2 answer pending fault or alarm code
// [R7] master drives serial clock on slave 1 bit 0, data on bit 1
// [R8] slave 1 input 2 carries device serial data, input 3 its clock
// [R9] four-byte serial word, cyclic or acyclic, carries the parameter channel
// [R10] slave 1 output bit 2 drives quick-stop override
// [R11] slave 1 inputs 0 and 1 show local inputs 2 and 3
// [R12] bus mode: slave 2 bit 0 run, bit 1 coast stop, bit 2 fault ack
// [R13] serial bit sampled on each toggle of its clock bit
// [R14] fault acknowledge acts on rising edge only
`timescale 1ns/100ps
module dual_slave_bit_interface (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] slave1_out,
	input wire logic [3:0] slave2_out,
	output logic [3:0] slave1_in,
	output logic [3:0] slave2_in,
	input wire logic local_input_0,
	input wire logic local_input_1,
	input wire logic local_input_2,
	input wire logic local_input_3,
	input wire logic diag_request,
	input wire logic drive_ready_on,
	input wire logic drive_pulses_en,
	output logic [2:0] fixed_speed_sel,
	output logic run_cmd,
	output logic coast_stop,
	output logic fault_ack,
	output logic quick_stop_override,
	output logic irq
);
	import dual_slave_pkg::*;

	function automatic logic rise(input logic cur, input logic prev);
		rise = cur & ~prev;
	endfunction : rise

	// pin synchroniser, three stages, change taken when stages 2 and 3 agree
	logic [SYNC_W-1:0] s1_r;
	logic [SYNC_W-1:0] s2_r;
	logic [SYNC_W-1:0] s3_r;
	logic [SYNC_W-1:0] clean_r;
	logic [SYNC_W-1:0] prev_r;
	wire [SYNC_W-1:0] raw = {diag_request, local_input_3, local_input_2, local_input_1,
		local_input_0, slave2_out, slave1_out};
	wire [SYNC_W-1:0] agree = ~(s2_r ^ s3_r);
	wire [SYNC_W-1:0] clean_nxt = (agree & s3_r) | (~agree & clean_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= SYNC_RESET;
			s2_r <= SYNC_RESET;
			s3_r <= SYNC_RESET;
			clean_r <= SYNC_RESET;
			prev_r <= SYNC_RESET;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			clean_r <= clean_nxt;
			prev_r <= clean_r;
		end
	end

	// slave fields [R1]
	wire [3:0] s1 = clean_r[SYN_S1_SEL:SYN_S1_CLK];
	wire [3:0] s2 = clean_r[SYN_S2_SEL:SYN_S2_LO];
	wire [3:0] loc = clean_r[SYN_LOCAL_LO+3:SYN_LOCAL_LO];
	wire diag = clean_r[SYN_DIAG];
	wire diag_rise = rise(diag, prev_r[SYN_DIAG]);
	wire ack_rise = rise(s2[2], prev_r[SYN_S2_LO+2]);

	// registers
	logic [1:0] ctrl_r;
	logic [3:0] irq_status_r;
	logic [3:0] irq_mask_r;
	logic [31:0] rx_data_r;
	logic [31:0] tx_data_r;
	logic [7:0] diag_code_r;
	logic tx_start_r;
	wire bus_mode = ctrl_r[CTRL_BUS_SETPOINT];

	// apb decode: answer in the first access cycle
	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire wr = access & pwrite;
	wire hit_ctrl = (paddr == CTRL_OFFSET);
	wire hit_status = (paddr == STATUS_OFFSET);
	wire hit_irqs = (paddr == IRQ_STATUS_OFFSET);
	wire hit_mask = (paddr == IRQ_MASK_OFFSET);
	wire hit_rx = (paddr == RX_DATA_OFFSET);
	wire hit_tx = (paddr == TX_DATA_OFFSET);
	wire hit_diag = (paddr == DIAG_CODE_OFFSET);
	wire mapped = hit_ctrl | hit_status | hit_irqs | hit_mask | hit_rx | hit_tx | hit_diag;
	wire tx_busy;
	wire tx_done;
	wire tx_data_bit;
	wire tx_clk_bit;
	wire [31:0] status_word = {21'h00000, s2[3], s1[3], tx_busy, quick_stop_override,
		coast_stop, run_cmd, fixed_speed_sel, 2'h0};
	wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
		hit_status ? status_word :
		hit_irqs ? {28'h0000000, irq_status_r} :
		hit_mask ? {28'h0000000, irq_mask_r} :
		hit_rx ? rx_data_r :
		hit_tx ? tx_data_r :
		hit_diag ? {24'h000000, diag_code_r} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
			pslverr <= setup & ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RESET;
			irq_mask_r <= IRQ_RESET;
			tx_data_r <= WORD_RESET;
			diag_code_r <= DIAG_RESET;
			tx_start_r <= 1'b0;
		end else begin
			tx_start_r <= wr & hit_ctrl & pwdata[CTRL_TX_START];
			if (wr & hit_ctrl) ctrl_r <= pwdata[1:0];
			if (wr & hit_mask) irq_mask_r <= pwdata[3:0];
			if (wr & hit_tx) tx_data_r <= pwdata;
			if (wr & hit_diag) diag_code_r <= pwdata[7:0];
		end
	end

	// serial receive from the master [R7]
	logic [31:0] rx_shift_r;
	logic [4:0] rx_cnt_r;
	logic rx_done_r;
	wire rx_toggle = s1[0] ^ prev_r[SYN_S1_CLK];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_shift_r <= WORD_RESET;
			rx_cnt_r <= 5'h00;
			rx_data_r <= WORD_RESET;
			rx_done_r <= 1'b0;
		end else begin
			rx_done_r <= 1'b0;
			if (rx_toggle) begin
				rx_shift_r <= {rx_shift_r[30:0], s1[1]}; // [R13]
				rx_cnt_r <= rx_cnt_r + 5'h01;
				if (rx_cnt_r == TX_LAST_BIT) begin
					rx_data_r <= {rx_shift_r[30:0], s1[1]}; // [R9]
					rx_done_r <= 1'b1;
				end
			end
		end
	end

	// bit-time divider for the transmit side
	logic [11:0] div_r;
	logic bit_en_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 12'h000;
			bit_en_r <= 1'b0;
		end else begin
			bit_en_r <= (div_r == TX_DIV_LAST);
			div_r <= (div_r == TX_DIV_LAST) ? 12'h000 : div_r + 12'h001;
		end
	end

	serial_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.bit_en(bit_en_r),
		.start(tx_start_r),
		.cyclic(ctrl_r[CTRL_CYCLIC]),
		.word(tx_data_r),
		.tx_data(tx_data_bit),
		.tx_clk(tx_clk_bit),
		.busy(tx_busy),
		.done(tx_done)
	);

	// drive commands
	wire [3:0] fault_code = diag_code_r[3:0];
	wire [3:0] alarm_code = diag_code_r[7:4];
	wire [3:0] diag_answer = (fault_code != 4'h0) ? fault_code : alarm_code;
	wire [3:0] normal_answer = {loc[1], loc[0], drive_pulses_en, drive_ready_on}; // [R5]
	wire [2:0] speed_code = s2[2:0]; // [R3]
	wire run_nxt = bus_mode ? s2[0] : (speed_code != 3'h0); // [R4] [R12]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fixed_speed_sel <= 3'h0;
			run_cmd <= 1'b0;
			coast_stop <= 1'b0;
			fault_ack <= 1'b0;
			quick_stop_override <= 1'b0;
			slave1_in <= 4'h0;
			slave2_in <= 4'h0;
		end else begin
			fixed_speed_sel <= bus_mode ? 3'h0 : speed_code; // [R3] [R4]
			run_cmd <= run_nxt;
			coast_stop <= bus_mode & s2[1]; // [R12]
			fault_ack <= bus_mode & ack_rise; // [R14]
			quick_stop_override <= s1[2]; // [R10]
			// select bits s1[3], s2[3] only feed status [R2]
			slave1_in <= {tx_clk_bit, tx_data_bit, loc[3], loc[2]}; // [R8] [R11]
			slave2_in <= diag ? diag_answer : normal_answer; // [R6]
		end
	end

	// sticky events, set wins over write-one clear
	wire [3:0] irq_set = {diag_rise, bus_mode & ack_rise, tx_done, rx_done_r};
	wire [3:0] irq_clr = (wr & hit_irqs) ? pwdata[3:0] : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_r <= IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
			irq <= |(irq_status_r & irq_mask_r);
		end
	end
endmodule : dual_slave_bit_interface

// File: bench/dual_slave_sva.sv
// assertion checker for the dual slave bit interface ports
`timescale 1ns/100ps
module dual_slave_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic [3:0] slave1_out,
	input wire logic [3:0] slave1_in,
	input wire logic local_input_2,
	input wire logic [2:0] fixed_speed_sel,
	input wire logic run_cmd,
	input wire logic coast_stop,
	input wire logic fault_ack,
	input wire logic quick_stop_override
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_answer_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
	qstop_follow_a: assert property ($past(presetn, 5) |->
		quick_stop_override == $past(slave1_out[2], 5)) else $error("quick stop lag wrong");
	local_follow_a: assert property ($past(presetn, 5) |->
		slave1_in[0] == $past(local_input_2, 5)) else $error("local input lag wrong");
	run_code_a: assert property (fixed_speed_sel != 3'h0 |-> run_cmd) else $error("speed code without run");
	coast_mode_a: assert property (coast_stop |-> fixed_speed_sel == 3'h0) else $error("coast in fixed mode");
	ack_pulse_a: assert property (fault_ack |=> !fault_ack) else $error("ack pulse too long");
	tx_order_a: assert property (slave1_in[3] != $past(slave1_in[3]) |->
		slave1_in[2] == $past(slave1_in[2])) else $error("tx data moved with clock");
endmodule : dual_slave_sva
bind dual_slave_bit_interface dual_slave_sva dual_slave_sva_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.prdata(prdata),
	.slave1_out(slave1_out),
	.slave1_in(slave1_in),
	.local_input_2(local_input_2),
	.fixed_speed_sel(fixed_speed_sel),
	.run_cmd(run_cmd),
	.coast_stop(coast_stop),
	.fault_ack(fault_ack),
	.quick_stop_override(quick_stop_override)
);

// File: bench/bus_master_model.sv
// serial side of the fieldbus master on slave 1
`timescale 1ns/100ps
module bus_master_model (
	input wire logic pclk,
	input wire logic [3:0] slave1_in,
	output logic ser_clk,
	output logic ser_data
);
	logic [31:0] got;
	int n;
	logic last;
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		got = 32'h0;
		n = 0;
		last = 1'b0;
	end
	// take device data on each toggle of its clock, msb first
	always @(posedge pclk) begin
		last <= slave1_in[3];
		if (slave1_in[3] !== last) begin
			got <= {got[30:0], slave1_in[2]};
			n <= n + 1;
		end
	end
	// data set well before each clock toggle; clock idles between frames
	task send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(posedge pclk);
			ser_data <= w[i];
			repeat (8) @(posedge pclk);
			ser_clk <= ~ser_clk;
			repeat (8) @(posedge pclk);
		end
		ser_data <= ~w[0];
	endtask : send
endmodule : bus_master_model

// File: bench/tb_top.sv
// self-checking testbench of the dual slave bit interface
`timescale 1ns/100ps
module tb_top;
	import dual_slave_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ser_clk, ser_data;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] s1_in, s2_in, s2_out;
	logic [1:0] s1_hi;
	logic [3:0] loc;
	logic diag, rdy, pen, run, coast, ack, qs, e;
	logic [2:0] fss;
	int errors, comparisons, acks;
	dual_slave_bit_interface dual_slave_bit_interface_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .slave1_out({s1_hi, ser_data, ser_clk}), .slave2_out(s2_out), .slave1_in(s1_in),
		.slave2_in(s2_in), .local_input_0(loc[0]), .local_input_1(loc[1]), .local_input_2(loc[2]),
		.local_input_3(loc[3]), .diag_request(diag), .drive_ready_on(rdy), .drive_pulses_en(pen),
		.fixed_speed_sel(fss), .run_cmd(run), .coast_stop(coast), .fault_ack(ack),
		.quick_stop_override(qs), .irq(irq));
	bus_master_model bus_master_model_i (.pclk(pclk), .slave1_in(s1_in), .ser_clk(ser_clk), .ser_data(ser_data));
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task end_of_test;
		$display("checks %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		#760000;
		errors++;
		end_of_test();
	end
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h0; pwdata = 32'h0;
		s1_hi = 2'h0; s2_out = 4'h0; loc = 4'h0; diag = 0; rdy = 0; pen = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		apb(0, CTRL_OFFSET, 0); chk("ctrl", r, 0);
		apb(0, IRQ_MASK_OFFSET, 0); chk("mask", r, 0);
		apb(0, 8'h1c, 0); chk("unmapped", {r[30:0], e}, 1);
		$display("test registers done");
		for (int c = 0; c < 8; c++) begin
			s2_out <= {1'b1, 3'(c)}; s1_hi <= 2'(c); loc <= 4'(c + 9); rdy <= c[0]; pen <= c[1];
			repeat (6) @(posedge pclk);
			chk("speed", fss, c);
			chk("run", run, c != 0);
			chk("qstop", qs, c[0]);
			chk("s1 in", s1_in[1:0], loc[3:2]);
			chk("s2 in", s2_in, {loc[1:0], c[1], c[0]});
			apb(0, STATUS_OFFSET, 0); chk("status", r[10:2], {1'b1, c[1], 1'b0, c[0], 1'b0, c != 0, 3'(c)});
		end
		$display("test fixed mode done");
		apb(1, CTRL_OFFSET, 1); s2_out <= 4'h3;
		repeat (6) @(posedge pclk);
		chk("bus run", {run, coast, fss}, 5'h18);
		s2_out <= 4'h4; acks = 0;
		repeat (20) @(negedge pclk) acks += ack;
		chk("ack count", acks, 1);
		chk("bus stop", {run, coast}, 0);
		apb(1, IRQ_MASK_OFFSET, 4); repeat (2) @(posedge pclk);
		chk("irq on", irq, 1);
		apb(1, IRQ_STATUS_OFFSET, 4); repeat (2) @(posedge pclk);
		chk("irq off", irq, 0);
		$display("test bus mode done");
		apb(1, DIAG_CODE_OFFSET, 32'h30); diag <= 1; repeat (6) @(posedge pclk);
		chk("alarm", s2_in, 3);
		apb(1, DIAG_CODE_OFFSET, 32'h35); repeat (3) @(posedge pclk);
		chk("fault", s2_in, 5);
		diag <= 0;
		$display("test diag done");
		bus_master_model_i.send(32'ha5c3_0f96);
		repeat (10) @(posedge pclk);
		apb(0, RX_DATA_OFFSET, 0); chk("rx word", r, 32'ha5c3_0f96);
		apb(0, IRQ_STATUS_OFFSET, 0); chk("rx flag", r[0], 1);
		$display("test rx done");
		apb(1, TX_DATA_OFFSET, 32'h6b1e_d207); apb(1, CTRL_OFFSET, 5);
		for (int t = 0; t < 90000 && bus_master_model_i.n < 32; t++) @(posedge pclk);
		repeat (5) @(posedge pclk);
		chk("tx word", bus_master_model_i.got, 32'h6b1e_d207);
		apb(0, STATUS_OFFSET, 0); chk("tx idle", r[8], 0);
		apb(0, IRQ_STATUS_OFFSET, 0); chk("irq flags", r[3:0], 4'hb);
		$display("test tx done");
		end_of_test();
	end
endmodule : tb_top
